/* File: dtp_pkg.sv */
// Constants for the DTMF transceiver host-side digital block
`default_nettype none
package dtp_pkg;
   // Reference clock and crystal rate
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned XTAL_HZ        = 3579545;
   // Settle delay from latch update to delayed-steering flag
   localparam int unsigned SETTLE_NS      = 100;
   localparam int unsigned SETTLE_CYC     =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Tone burst and pause lengths in burst mode
   localparam int unsigned BURST_MS       = 51;
   localparam int unsigned BURST_CYC      =
      BURST_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [3:0]  CODE_RESET     = 4'h0;
   localparam logic [1:0]  CHOOSE_RX_DATA = 2'h0;

   typedef enum logic [1:0] {
      DTP_TX_IDLE  = 2'b00,
      DTP_TX_BURST = 2'b01,
      DTP_TX_PAUSE = 2'b10
   } dtp_tx_state_t;

   // Row/column index pair (0..3 each) to 4-bit output code
   function automatic logic [3:0] dtp_code(input logic [1:0] row,
                                           input logic [1:0] col);
      logic [3:0] c;
      c = 4'h0;
      if (col == 2'h3)
         c = (row == 2'h3) ? 4'h0 : 4'(4'hd + {2'b00, row});
      else if (row == 2'h3)
         c = (col == 2'h0) ? 4'hb : ((col == 2'h1) ? 4'ha : 4'hc);
      else
         c = 4'(({2'b00, row} * 4'h3) + {2'b00, col} + 4'h1);
      return c;
   endfunction
endpackage
`default_nettype wire

/* File: dtp_host_port.sv */
// Host port, steering and power-down logic of the DTMF transceiver
//
// Function
// - Float data bus when deselected or idle strobe
// - Shared pin is direction or write strobe
// - Interrupt mode pulls output low after burst
// - Progress mode echoes in-band input square wave
// - Sleep pin powers down, stops oscillator
// - Sleep floats interrupt, tone, data bus
// - Early valid rises on valid tone pair
// - Loss of pair drops early valid immediately
// - Steering above threshold registers and latches code
// - Steering below threshold allows new pair
// - Guard output from early valid and steering
// - Crystal or external clock at 3.579545 MHz
// - Transmitter, receiver power down independently
// - Counters time tone bursts and pauses
// - Selectable call-progress filter mode
// - Latch four-bit code per mapping table
// - Delayed steering flag after settle, interrupts
// - Both sleep bits stop oscillator, float outputs
`default_nettype none
module dtp_host_port #(
   parameter int unsigned BURST_CYCLES = dtp_pkg::BURST_CYC
) (
   input  wire logic       ref_clk,          // 40 MHz clock
   input  wire logic       rst_b,            // Async reset, active low
   input  wire logic       chip_sel_b,       // Chip select, active low
   input  wire logic       split_strobes,    // 1: separate read/write
   input  wire logic       rw_or_wr_b,       // Direction or write strobe
   input  wire logic       data_strobe,      // Data strobe or read_b
   input  wire logic       register_choose,  // Register select
   input  wire logic [3:0] host_nibble_in,   // Bus input
   output logic      [3:0] host_nibble_out,  // Bus output data
   output logic            host_nibble_oe,   // Bus drive enable
   input  wire logic       sleep_pin,        // Power down, active high
   input  wire logic       rx_sleep_bit,     // Receiver power down
   input  wire logic       tx_off_bit,       // Transmitter disable
   input  wire logic       irq_mode,         // 1: interrupt mode
   input  wire logic       progress_mode,    // Call-progress filter on
   input  wire logic       progress_level,   // In-band limiter output
   input  wire logic       pair_valid,       // Detector sees valid pair
   input  wire logic [1:0] pair_row,         // Detected row index
   input  wire logic [1:0] pair_col,         // Detected column index
   input  wire logic       steer_above,      // Steering above threshold
   input  wire logic       tx_start,         // Start a tone burst
   output logic            early_tone_valid, // Early steering output
   output logic            guard_out,        // Guard drive level (high)
   output logic            guard_oe,         // Guard drive enable
   output logic            int_out_oe,       // Open drain pulls low
   output logic            tone_oe,          // Tone output enable
   output logic            tone_on,          // Tone generator gated on
   output logic            osc_run,          // Oscillator enable
   output logic            rx_powered,       // Receiver powered
   output logic            tx_powered,       // Transmitter powered
   output logic            delayed_steer,    // Registered flag
   output logic      [3:0] rx_code           // Latched tone code
);
   // =========================================================
   // Reset release and steering synchroniser
   // =========================================================
   logic [1:0] rstSync_r;
   logic       rstB;
   logic       stMeta_r, stSync_r, stPrev_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync_r <= 2'b00;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstB = rstSync_r[1];

   always_ff @(posedge ref_clk or negedge rstB) begin
      if (!rstB) begin
         stMeta_r <= 1'b0;
         stSync_r <= 1'b0;
         stPrev_r <= 1'b0;
      end else begin
         stMeta_r <= steer_above;
         stSync_r <= stMeta_r;
         stPrev_r <= stSync_r;
      end
   end

   // =========================================================
   // Power state
   // =========================================================
   logic allDown;
   always_comb begin
      allDown    = sleep_pin | (rx_sleep_bit & tx_off_bit);
      osc_run    = !allDown;
      rx_powered = !sleep_pin && !rx_sleep_bit;
      tx_powered = !sleep_pin && !tx_off_bit;
   end

   // =========================================================
   // Early steering and guard time
   // =========================================================
   always_comb begin
      early_tone_valid = rx_powered & pair_valid;
      // Guard drives steering node high while registered and pair holds
      guard_oe  = early_tone_valid & stSync_r;
      guard_out = 1'b1;
   end

   // =========================================================
   // Registration, code latch and delayed steering
   // =========================================================
   logic [3:0] code_r, code_nxt;
   logic [3:0] settle_r, settle_nxt;
   logic       dstf_r, dstf_nxt;
   logic       txDone_r, txDone_nxt;
   logic       readRx;
   always_comb begin
      code_nxt   = code_r;
      settle_nxt = settle_r;
      dstf_nxt   = dstf_r;
      if (rx_powered && stSync_r && !stPrev_r) begin
         code_nxt   = dtp_pkg::dtp_code(pair_row,
                                        pair_col);
         settle_nxt = 4'(dtp_pkg::SETTLE_CYC);
      end else if (settle_r != 4'h0) begin
         settle_nxt = settle_r - 4'h1;
         if (settle_r == 4'h1)
            dstf_nxt = 1'b1;
      end else if (!stSync_r && readRx) begin
         dstf_nxt = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge rstB) begin
      if (!rstB) begin
         code_r   <= dtp_pkg::CODE_RESET;
         settle_r <= 4'h0;
         dstf_r   <= 1'b0;
      end else begin
         code_r   <= code_nxt;
         settle_r <= settle_nxt;
         dstf_r   <= dstf_nxt;
      end
   end
   assign rx_code       = code_r;
   assign delayed_steer = dstf_r;

   // =========================================================
   // Burst timer
   // =========================================================
   dtp_pkg::dtp_tx_state_t txSt_r, txSt_nxt;
   logic [31:0] txCnt_r, txCnt_nxt;
   always_comb begin
      txSt_nxt    = txSt_r;
      txCnt_nxt   = txCnt_r;
      txDone_nxt  = txDone_r;
      if (readRx)
         txDone_nxt = 1'b0;
      case (txSt_r)
         dtp_pkg::DTP_TX_IDLE: begin
            if (tx_start && tx_powered) begin
               txSt_nxt  = dtp_pkg::DTP_TX_BURST;
               txCnt_nxt = BURST_CYCLES - 1;
            end
         end
         dtp_pkg::DTP_TX_BURST: begin
            if (txCnt_r == 32'h0) begin
               txSt_nxt   = dtp_pkg::DTP_TX_PAUSE;
               txCnt_nxt  = BURST_CYCLES - 32'h1;
               txDone_nxt = 1'b1;
            end else begin
               txCnt_nxt = txCnt_r - 32'h1;
            end
         end
         dtp_pkg::DTP_TX_PAUSE: begin
            if (txCnt_r == 32'h0)
               txSt_nxt = dtp_pkg::DTP_TX_IDLE;
            else
               txCnt_nxt = txCnt_r - 32'h1;
         end
         default: txSt_nxt = dtp_pkg::DTP_TX_IDLE;
      endcase
      if (!tx_powered) begin
         txSt_nxt  = dtp_pkg::DTP_TX_IDLE;
         txCnt_nxt = 32'h0;
      end
   end
   always_ff @(posedge ref_clk or negedge rstB) begin
      if (!rstB) begin
         txSt_r   <= dtp_pkg::DTP_TX_IDLE;
         txCnt_r  <= 32'h0;
         txDone_r <= 1'b0;
      end else begin
         txSt_r   <= txSt_nxt;
         txCnt_r  <= txCnt_nxt;
         txDone_r <= txDone_nxt;
      end
   end
   assign tone_on = (txSt_r == dtp_pkg::DTP_TX_BURST);
   assign tone_oe = tx_powered && !allDown;

   // =========================================================
   // Host bus and interrupt / progress pin
   // =========================================================
   logic readAct;
   always_comb begin
      // Strobes matter only with chip select low; idle otherwise
      if (split_strobes)
         readAct = !chip_sel_b && !data_strobe;
      else
         readAct = !chip_sel_b && data_strobe && rw_or_wr_b;
      readRx = readAct && (register_choose == dtp_pkg::CHOOSE_RX_DATA[0]);
      host_nibble_oe  = readAct && !allDown;
      host_nibble_out = readRx ? code_r
                               : {txDone_r, dstf_r, 2'b00};
      if (allDown)
         int_out_oe = 1'b0;
      else if (progress_mode)
         int_out_oe = rx_powered & !progress_level;
      else
         int_out_oe = irq_mode & (dstf_r | txDone_r);
   end

   // =========================================================
   // Checks
   // =========================================================
   a_bus_float: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      (chip_sel_b || sleep_pin) |-> !host_nibble_oe)
      else $error("data bus driven while deselected");
   a_sleep_quiet: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      sleep_pin |-> !int_out_oe && !tone_oe && !osc_run)
      else $error("outputs active in sleep");
   a_early_follow: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      (rx_powered && !pair_valid) |-> !early_tone_valid)
      else $error("early valid without pair");
   a_latch_code: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      (rx_powered && stSync_r && !stPrev_r) |=>
         rx_code == dtp_pkg::dtp_code($past(pair_row), $past(pair_col)))
      else $error("code not latched on steering rise");
   a_flag_delay: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      (settle_r == 4'h1) |=> delayed_steer)
      else $error("delayed flag missing after settle");
   a_sync_lag: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      $rose(steer_above) ##1 steer_above |=> stSync_r)
      else $error("steering not synchronised in two cycles");
   a_guard_level: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      (guard_oe == (early_tone_valid && stSync_r)) && guard_out)
      else $error("guard drive does not follow its causes");
   a_both_bits: assert property (
      @(posedge ref_clk) disable iff (!rstB)
      (rx_sleep_bit && tx_off_bit) |-> !osc_run && !host_nibble_oe)
      else $error("oscillator running with both bits set");
endmodule
`default_nettype wire

/* File: dtp_host_model.sv */
// Host processor model driving the adaptive port of the transceiver
`default_nettype none
module dtp_host_model (
   input  wire logic       ref_clk,         // Bench clock
   input  wire logic [3:0] host_nibble_out, // Device bus output
   input  wire logic       host_nibble_oe,  // Device bus enable
   output logic            chip_sel_b,      // Gated chip select
   output logic            split_strobes,   // Host bus style
   output logic            rw_or_wr_b,      // Direction or write strobe
   output logic            data_strobe,     // Data or read strobe
   output logic            register_choose  // Register select
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chip_sel_b = 1'b1;
      split_strobes = 1'b0;
      rw_or_wr_b = 1'b1;
      data_strobe = 1'b0;
      register_choose = 1'b0;
   end
   // Select only inside a cycle, as an address-strobe gate would
   task automatic idle(input logic split);
      @(negedge ref_clk);
      chip_sel_b = 1'b1;
      split_strobes = split;
      rw_or_wr_b = 1'b1;
      data_strobe = split;
   endtask
   // Selected first with strobe idle, so the bus must still float
   task automatic rd(input logic split, input logic sel,
                     output logic [3:0] d, output logic oe,
                     output logic oe0);
      idle(split);
      @(negedge ref_clk);
      chip_sel_b = 1'b0;
      register_choose = sel;
      @(negedge ref_clk);
      oe0 = host_nibble_oe;
      data_strobe = ~split;
      @(negedge ref_clk);
      d = host_nibble_out;
      oe = host_nibble_oe;
      idle(split);
   endtask
endmodule
`default_nettype wire

/* File: test_dtp_host_port.sv */
// Self-checking bench for the host port and steering logic
`default_nettype none
module test_dtp_host_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic refClk, rstB, chipSelB, splitStb, rwOrWrB, dataStrobe, regCh;
   logic nibOe, sleepPin, rxSleep, txOff, irqMode, progMode, progLevel;
   logic pairValid, steer, txStart, early, guardOut, guardOe, intOe;
   logic toneOe, toneOn, oscRun, rxPow, txPow, dSteer, oe, oe0;
   logic [3:0] nibOut, rxCode, d;
   logic [1:0] row, col;
   int nFail, totalChecks, cyc;
   logic [3:0] codes [16] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6,
      4'he, 4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};
   initial begin
      refClk = 1'b0;
      forever #12.5 refClk = ~refClk;
   end
   dtp_host_port #(.BURST_CYCLES(8)) dut (.ref_clk(refClk), .rst_b(rstB),
      .chip_sel_b(chipSelB), .split_strobes(splitStb),
      .rw_or_wr_b(rwOrWrB), .data_strobe(dataStrobe),
      .register_choose(regCh), .host_nibble_in(4'h0),
      .host_nibble_out(nibOut), .host_nibble_oe(nibOe),
      .sleep_pin(sleepPin), .rx_sleep_bit(rxSleep), .tx_off_bit(txOff),
      .irq_mode(irqMode), .progress_mode(progMode),
      .progress_level(progLevel), .pair_valid(pairValid), .pair_row(row),
      .pair_col(col), .steer_above(steer), .tx_start(txStart),
      .early_tone_valid(early), .guard_out(guardOut), .guard_oe(guardOe),
      .int_out_oe(intOe), .tone_oe(toneOe), .tone_on(toneOn),
      .osc_run(oscRun), .rx_powered(rxPow), .tx_powered(txPow),
      .delayed_steer(dSteer), .rx_code(rxCode));
   dtp_host_model host (.ref_clk(refClk), .host_nibble_out(nibOut),
      .host_nibble_oe(nibOe), .chip_sel_b(chipSelB),
      .split_strobes(splitStb), .rw_or_wr_b(rwOrWrB),
      .data_strobe(dataStrobe), .register_choose(regCh));
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nFail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (nFail == 0 && totalChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Ceiling well above the roughly 340 cycles the sequence needs
   always @(posedge refClk) begin
      cyc++;
      if (cyc == 5000) begin
         nFail++;
         conclude();
      end
   end
   initial begin
      {rstB, irqMode, progMode, progLevel, pairValid, steer} = 6'h0;
      {rxSleep, txOff, txStart, row, col} = 7'h0;
      sleepPin = 1'b0;
      repeat (8) @(negedge refClk);
      rstB = 1'b1;
      repeat (4) @(negedge refClk);
      chk({dSteer, rxCode[2:0]}, 4'h0);
      chk({nibOe, rxCode[3], oscRun, 1'b0}, 4'h2);
      irqMode = 1'b1;
      for (int i = 0; i < 16; i++) begin
         row = 2'(i >> 2);
         col = 2'(i);
         pairValid = 1'b1;
         @(negedge refClk);
         chk({3'h0, early}, 4'h1);
         steer = 1'b1;
         repeat (8) @(negedge refClk);
         chk(rxCode, codes[i]);
         chk({dSteer, intOe, guardOe, 1'b0}, 4'he);
         pairValid = 1'b0;
         steer = 1'b0;
         #1;
         chk({early, guardOe, 2'h0}, 4'h0);
         repeat (4) @(negedge refClk);
         host.rd(1'(i), 1'b0, d, oe, oe0);
         chk(d, codes[i]);
         chk({oe, oe0, dSteer, 1'b0}, 4'h8);
      end
      // A different pair, so a wrong registration would show
      {row, col} = 4'h0;
      rxSleep = 1'b1;
      pairValid = 1'b1;
      steer = 1'b1;
      repeat (8) @(negedge refClk);
      chk({early, rxPow, txPow, dSteer}, 4'h2);
      chk(rxCode, codes[15]);
      {rxSleep, pairValid, steer, irqMode, progMode} = 5'h1;
      @(negedge refClk);
      chk({3'h0, intOe}, 4'h1);
      progLevel = 1'b1;
      @(negedge refClk);
      chk({3'h0, intOe}, 4'h0);
      {progMode, irqMode, txStart} = 3'h3;
      @(negedge refClk);
      txStart = 1'b0;
      repeat (2) @(negedge refClk);
      chk({toneOn, toneOe, 2'h0}, 4'hc);
      // Last cycle of the burst, then the first of the pause
      repeat (5) @(negedge refClk);
      chk({toneOn, intOe, 2'h0}, 4'h8);
      @(negedge refClk);
      chk({toneOn, intOe, 2'h0}, 4'h4);
      host.rd(1'b1, 1'b1, d, oe, oe0);
      chk({3'h0, d[3]}, 4'h1);
      // Start during the pause must be ignored
      txStart = 1'b1;
      @(negedge refClk);
      txStart = 1'b0;
      chk({3'h0, toneOn}, 4'h0);
      sleepPin = 1'b1;
      host.rd(1'b0, 1'b0, d, oe, oe0);
      chk({oe, intOe, toneOe, oscRun}, 4'h0);
      sleepPin = 1'b0;
      {rxSleep, txOff} = 2'h3;
      host.rd(1'b1, 1'b0, d, oe, oe0);
      chk({oe, intOe, toneOe, oscRun}, 4'h0);
      conclude();
   end
endmodule
`default_nettype wire
